// >>> pkg/i2c_mem_pkg.sv
// ============================================================
// constants of the two-address memory slave
package i2c_mem_pkg;

  // ==========================================================
  // slave addresses, kept as full address bytes
  localparam logic [7:0] AUX_SLAVE_ADDR     = 8'hA0;
  localparam logic [7:0] MAIN_ADDR_RESET    = 8'hA2;

  // ==========================================================
  // main-memory locations that steer the slave
  localparam logic [7:0] REG_SHADOW_CTRL     = 8'h80;
  localparam int         SHADOW_BYPASS_BIT   = 0;
  localparam logic [7:0] REG_ADDR_SELECT     = 8'h89;
  localparam int         ADDR_SELECT_BIT     = 0;
  localparam logic [7:0] REG_MAIN_SLAVE_ADDR = 8'h8C;
  localparam logic [7:0] SHADOW_CTRL_RESET   = 8'h00;
  // main address live from reset: with it off the main memory, and so the
  // enable bit itself, could never be reached
  localparam logic [7:0] ADDR_SELECT_RESET   = 8'h01;

  // ==========================================================
  // framing
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam int         ROW_BYTES     = 8;
  localparam int         MEM_BYTES     = 256;

  typedef enum logic [1:0] {
    PH_SLAVE   = 2'h0,
    PH_MEMADDR = 2'h1,
    PH_DATA    = 2'h3
  } byte_phase_e;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_RX     = 3'h1,
    ST_RX_ACK = 3'h3,
    ST_TX     = 3'h2,
    ST_TX_ACK = 3'h6
  } link_state_e;

  // ==========================================================
  // programming time
  localparam int EEPROM_PROGRAM_TIME_US = 10000;
  localparam int CLK_MHZ                = 10;
  localparam int EEPROM_PROGRAM_CYCLES  = EEPROM_PROGRAM_TIME_US * CLK_MHZ;
  localparam int PROG_CNT_W             = 20;

endpackage : i2c_mem_pkg

// >>> src/dual_address_i2c_memory_slave.sv
// Behaviour
// - sda falling while scl high is start
// - sda rising while scl high is stop
// - repeated start restarts address reception
// - sample incoming bits on scl rise
// - drive outgoing bits at scl fall
// - ninth bit is ack low, nack high
// - eight bits msb first, then ack
// - first byte: 7-bit address plus direction
// - auxiliary memory answers fixed address A0h
// - main memory answers programmable address byte
// - main address decoded only when enabled
// - direction 0 writes, 1 reads
// - unmatched address: ignore until next start
// - main address A0h disables auxiliary memory while main is enabled
// - second write byte loads address counter
// - store byte at counter, then advance
// - write counter wraps inside 8-byte row
// - nack own address while programming
// - programming keeps untouched row bytes
// - read starts at current counter
// - shadow bypass skips programming and busy for main-memory writes only
`timescale 1ns/1ns
`default_nettype none

module dual_address_i2c_memory_slave #(
  parameter int PROGRAM_CYCLES = i2c_mem_pkg::EEPROM_PROGRAM_CYCLES
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic link_clk,
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  output logic      eeprom_busy
);

  // ==========================================================
  // functions
  function automatic logic [7:0] next_in_row(input logic [7:0] a);
    next_in_row = {a[7:3], a[2:0] + 3'h1};
  endfunction : next_in_row

  function automatic logic addr_match(input logic [7:0] rx, input logic [7:0] ref_addr);
    addr_match = (rx[7:1] == ref_addr[7:1]);
  endfunction : addr_match

  // ==========================================================
  // pin synchronisers on the link clock
  logic scl_meta_ff;
  logic scl_sync_ff;
  logic scl_prev_ff;
  logic sda_meta_ff;
  logic sda_sync_ff;
  logic sda_prev_ff;

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_meta_ff <= 1'b1;
      scl_sync_ff <= 1'b1;
      scl_prev_ff <= 1'b1;
      sda_meta_ff <= 1'b1;
      sda_sync_ff <= 1'b1;
      sda_prev_ff <= 1'b1;
    end else begin
      scl_meta_ff <= scl_in;
      scl_sync_ff <= scl_meta_ff;
      scl_prev_ff <= scl_sync_ff;
      sda_meta_ff <= sda_in;
      sda_sync_ff <= sda_meta_ff;
      sda_prev_ff <= sda_sync_ff;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  assign scl_rise   = scl_sync_ff & ~scl_prev_ff;
  assign scl_fall   = ~scl_sync_ff & scl_prev_ff;
  assign start_seen = scl_sync_ff & scl_prev_ff & sda_prev_ff & ~sda_sync_ff;
  assign stop_seen  = scl_sync_ff & scl_prev_ff & ~sda_prev_ff & sda_sync_ff;

  // ==========================================================
  // declarations of the link-side state
  i2c_mem_pkg::link_state_e state_ff;
  i2c_mem_pkg::byte_phase_e phase_ff;
  logic [3:0] bit_cnt_ff;
  logic [7:0] rx_sh_ff;
  logic [7:0] tx_sh_ff;
  logic [7:0] addr_cnt_ff;
  logic       dir_read_ff;
  logic       sel_aux_ff;
  logic       oe_ff;
  logic       wrote_ff;
  logic       prog_tgl_ff;
  logic       pend_ff;
  logic       busy_meta_ff;
  logic       busy_sync_ff;
  logic [7:0] shadow_ctrl_ff;
  logic [7:0] addr_select_ff;
  logic [7:0] main_addr_ff;
  logic [7:0] main_mem [i2c_mem_pkg::MEM_BYTES];
  logic [7:0] aux_mem  [i2c_mem_pkg::MEM_BYTES];

  // ==========================================================
  // address decode
  logic main_en;
  logic main_hit;
  logic aux_hit;
  logic busy_eff;
  logic rx_done;
  logic wr_en;
  logic bypass;

  assign main_en  = addr_select_ff[i2c_mem_pkg::ADDR_SELECT_BIT];
  assign main_hit = main_en & addr_match(rx_sh_ff, main_addr_ff);
  // a main address of A0h takes the auxiliary address over while main is enabled
  assign aux_hit  = addr_match(rx_sh_ff, i2c_mem_pkg::AUX_SLAVE_ADDR) &
                    ~(main_en & addr_match(main_addr_ff, i2c_mem_pkg::AUX_SLAVE_ADDR));
  assign busy_eff = pend_ff | busy_sync_ff;
  assign rx_done  = (state_ff == i2c_mem_pkg::ST_RX) && scl_fall &&
                    (bit_cnt_ff == i2c_mem_pkg::BITS_PER_BYTE);
  assign wr_en    = rx_done && (phase_ff == i2c_mem_pkg::PH_DATA);
  assign bypass   = ~sel_aux_ff & shadow_ctrl_ff[i2c_mem_pkg::SHADOW_BYPASS_BIT];

  // ==========================================================
  // read data
  logic [7:0] rd_data;

  always_comb begin
    if (sel_aux_ff) begin
      rd_data = aux_mem[addr_cnt_ff];
    end else if (addr_cnt_ff == i2c_mem_pkg::REG_SHADOW_CTRL) begin
      rd_data = shadow_ctrl_ff;
    end else if (addr_cnt_ff == i2c_mem_pkg::REG_ADDR_SELECT) begin
      rd_data = addr_select_ff;
    end else if (addr_cnt_ff == i2c_mem_pkg::REG_MAIN_SLAVE_ADDR) begin
      rd_data = main_addr_ff;
    end else begin
      rd_data = main_mem[addr_cnt_ff];
    end
  end

  // ==========================================================
  // protocol engine
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff    <= i2c_mem_pkg::ST_IDLE;
      phase_ff    <= i2c_mem_pkg::PH_SLAVE;
      bit_cnt_ff  <= 4'h0;
      rx_sh_ff    <= 8'h00;
      tx_sh_ff    <= 8'h00;
      addr_cnt_ff <= 8'h00;
      dir_read_ff <= 1'b0;
      sel_aux_ff  <= 1'b0;
      oe_ff       <= 1'b0;
    end else if (start_seen) begin
      state_ff   <= i2c_mem_pkg::ST_RX;
      phase_ff   <= i2c_mem_pkg::PH_SLAVE;
      bit_cnt_ff <= 4'h0;
      oe_ff      <= 1'b0;
    end else if (stop_seen) begin
      state_ff <= i2c_mem_pkg::ST_IDLE;
      oe_ff    <= 1'b0;
    end else begin
      unique case (state_ff)
        i2c_mem_pkg::ST_IDLE: begin
          oe_ff <= 1'b0;
        end
        i2c_mem_pkg::ST_RX: begin
          if (scl_rise && bit_cnt_ff != i2c_mem_pkg::BITS_PER_BYTE) begin
            rx_sh_ff   <= {rx_sh_ff[6:0], sda_sync_ff};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (rx_done) begin
            unique case (phase_ff)
              i2c_mem_pkg::PH_SLAVE: begin
                if ((main_hit | aux_hit) && !busy_eff) begin
                  oe_ff       <= 1'b1;
                  dir_read_ff <= rx_sh_ff[0];
                  sel_aux_ff  <= aux_hit;
                  state_ff    <= i2c_mem_pkg::ST_RX_ACK;
                end else begin
                  state_ff <= i2c_mem_pkg::ST_IDLE;
                end
              end
              i2c_mem_pkg::PH_MEMADDR: begin
                addr_cnt_ff <= rx_sh_ff;
                phase_ff    <= i2c_mem_pkg::PH_DATA;
                oe_ff       <= 1'b1;
                state_ff    <= i2c_mem_pkg::ST_RX_ACK;
              end
              default: begin
                addr_cnt_ff <= next_in_row(addr_cnt_ff);
                oe_ff       <= 1'b1;
                state_ff    <= i2c_mem_pkg::ST_RX_ACK;
              end
            endcase
          end
        end
        i2c_mem_pkg::ST_RX_ACK: begin
          if (scl_fall) begin
            if (phase_ff == i2c_mem_pkg::PH_SLAVE && dir_read_ff) begin
              tx_sh_ff   <= rd_data;
              oe_ff      <= ~rd_data[7];
              bit_cnt_ff <= 4'h1;
              state_ff   <= i2c_mem_pkg::ST_TX;
            end else begin
              oe_ff      <= 1'b0;
              bit_cnt_ff <= 4'h0;
              state_ff   <= i2c_mem_pkg::ST_RX;
              if (phase_ff == i2c_mem_pkg::PH_SLAVE) begin
                phase_ff <= i2c_mem_pkg::PH_MEMADDR;
              end
            end
          end
        end
        i2c_mem_pkg::ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_ff == i2c_mem_pkg::BITS_PER_BYTE) begin
              oe_ff       <= 1'b0;
              addr_cnt_ff <= addr_cnt_ff + 8'h01;
              state_ff    <= i2c_mem_pkg::ST_TX_ACK;
            end else begin
              tx_sh_ff   <= {tx_sh_ff[6:0], 1'b0};
              oe_ff      <= ~tx_sh_ff[6];
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
        end
        i2c_mem_pkg::ST_TX_ACK: begin
          if (scl_rise && sda_sync_ff) begin
            state_ff <= i2c_mem_pkg::ST_IDLE;
          end else if (scl_fall) begin
            tx_sh_ff   <= rd_data;
            oe_ff      <= ~rd_data[7];
            bit_cnt_ff <= 4'h1;
            state_ff   <= i2c_mem_pkg::ST_TX;
          end
        end
        default: begin
          state_ff <= i2c_mem_pkg::ST_IDLE;
          oe_ff    <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // storage; bytes are kept one by one so the rest of the row survives
  always_ff @(posedge link_clk) begin
    if (wr_en) begin
      if (sel_aux_ff) begin
        aux_mem[addr_cnt_ff] <= rx_sh_ff;
      end else begin
        main_mem[addr_cnt_ff] <= rx_sh_ff;
      end
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      shadow_ctrl_ff <= i2c_mem_pkg::SHADOW_CTRL_RESET;
      addr_select_ff <= i2c_mem_pkg::ADDR_SELECT_RESET;
      main_addr_ff   <= i2c_mem_pkg::MAIN_ADDR_RESET;
    end else if (wr_en && !sel_aux_ff) begin
      if (addr_cnt_ff == i2c_mem_pkg::REG_SHADOW_CTRL) begin
        shadow_ctrl_ff <= rx_sh_ff;
      end
      if (addr_cnt_ff == i2c_mem_pkg::REG_ADDR_SELECT) begin
        addr_select_ff <= rx_sh_ff;
      end
      if (addr_cnt_ff == i2c_mem_pkg::REG_MAIN_SLAVE_ADDR) begin
        main_addr_ff <= rx_sh_ff;
      end
    end
  end

  // ==========================================================
  // page programming request, handed to the core clock by toggle
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      wrote_ff    <= 1'b0;
      prog_tgl_ff <= 1'b0;
      pend_ff     <= 1'b0;
    end else begin
      if (wr_en) begin
        wrote_ff <= 1'b1;
      end else if (stop_seen) begin
        wrote_ff <= 1'b0;
      end
      if (stop_seen && wrote_ff && !bypass) begin
        prog_tgl_ff <= ~prog_tgl_ff;
      end
      // pend covers the crossing delay until busy comes back
      if (stop_seen && wrote_ff && !bypass) begin
        pend_ff <= 1'b1;
      end else if (busy_sync_ff) begin
        pend_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy_meta_ff <= 1'b0;
      busy_sync_ff <= 1'b0;
    end else begin
      busy_meta_ff <= eeprom_busy;
      busy_sync_ff <= busy_meta_ff;
    end
  end

  // ==========================================================
  // programming timer on the core clock
  logic                              prog_meta_ff;
  logic                              prog_sync_ff;
  logic                              prog_prev_ff;
  logic [i2c_mem_pkg::PROG_CNT_W-1:0] prog_cnt_ff;
  logic                              busy_ff;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_meta_ff <= 1'b0;
      prog_sync_ff <= 1'b0;
      prog_prev_ff <= 1'b0;
    end else begin
      prog_meta_ff <= prog_tgl_ff;
      prog_sync_ff <= prog_meta_ff;
      prog_prev_ff <= prog_sync_ff;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_cnt_ff <= '0;
      busy_ff     <= 1'b0;
    end else if (prog_sync_ff != prog_prev_ff) begin
      prog_cnt_ff <= i2c_mem_pkg::PROG_CNT_W'(PROGRAM_CYCLES);
      busy_ff     <= 1'b1;
    end else if (prog_cnt_ff != '0) begin
      prog_cnt_ff <= prog_cnt_ff - 1'b1;
      busy_ff     <= (prog_cnt_ff != i2c_mem_pkg::PROG_CNT_W'(1));
    end else begin
      busy_ff <= 1'b0;
    end
  end

  // ==========================================================
  // outputs; open drain, so the level driven is always low
  assign sda_out     = 1'b0;
  assign sda_oe      = oe_ff;
  assign eeprom_busy = busy_ff;

endmodule : dual_address_i2c_memory_slave

`default_nettype wire

// >>> test/i2c_master_model.sv
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model #(
  parameter int QUARTER_NS = 400
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // =====
  // idle bus: both lines released and still
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  task automatic start;
    sda_low = 1'b0;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS sda_low = 1'b1;
    #QUARTER_NS scl = 1'b0;
    #QUARTER_NS;
  endtask : start
  task automatic stop;
    sda_low = 1'b1;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS sda_low = 1'b0;
    #QUARTER_NS;
  endtask : stop
  // sda only moves a quarter into scl low, well after the slave's own change
  task automatic bit_io(input logic b, output logic r);
    sda_low = !b;
    #QUARTER_NS scl = 1'b1;
    #QUARTER_NS r = sda;
    #QUARTER_NS scl = 1'b0;
    #QUARTER_NS;
  endtask : bit_io
  task automatic xfer(input logic [7:0] d, input logic last, output logic [7:0] q,
                      output logic a);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
      q[i] = r;
    end
    bit_io(last, a);
  endtask : xfer
endmodule : i2c_master_model
`default_nettype wire

// >>> test/slave_checker.sv
`timescale 1ns/1ns
`default_nettype none
module slave_checker #(
  parameter int PROGRAM_CYCLES = 50
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic eeprom_busy
);
  // =====
  // frame tracking straight off the pins
  logic       scl_q, sda_q, in_frame_ff;
  logic [3:0] rises_ff;
  int         busy_cnt_ff;
  always_ff @(posedge link_clk or negedge reset_n) begin
    if (!reset_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      in_frame_ff <= 1'b0;
      rises_ff <= 4'h0;
    end else begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      if (scl_in && scl_q && sda_q && !sda_in) begin
        in_frame_ff <= 1'b1;
        rises_ff <= 4'h0;
      end else begin
        if (scl_in && scl_q && !sda_q && sda_in) in_frame_ff <= 1'b0;
        if (scl_in && !scl_q && rises_ff != 4'hF) rises_ff <= rises_ff + 4'h1;
      end
    end
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) busy_cnt_ff <= 0;
    else busy_cnt_ff <= eeprom_busy ? busy_cnt_ff + 1 : 0;
  end
  // =====
  // assertions
  sequence s_oe_up;
    $rose(sda_oe);
  endsequence
  sequence s_after_fall;
    !$past(scl_in, 2) && $past(scl_in, 7);
  endsequence
  drive_zero_a: assert property (@(posedge link_clk) disable iff (!reset_n) sda_out == 1'b0)
    else $error("sda_out not low");
  oe_low_scl_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    $changed(sda_oe) |-> !scl_in && !$past(scl_in, 2)) else $error("sda moved in scl high");
  oe_rise_delay_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    s_oe_up |-> s_after_fall) else $error("sda drive not after scl fall");
  addr_ack_pos_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    s_oe_up and rises_ff < 4'h9 |-> rises_ff == 4'h8) else $error("early drive in frame");
  idle_quiet_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    !in_frame_ff |-> !sda_oe) else $error("sda driven outside frame");
  busy_quiet_a: assert property (@(posedge link_clk) disable iff (!reset_n)
    eeprom_busy |-> !sda_oe) else $error("sda driven while busy");
  busy_len_a: assert property (@(posedge clk) disable iff (!reset_n)
    $fell(eeprom_busy) |-> busy_cnt_ff == PROGRAM_CYCLES) else $error("busy length wrong");
  busy_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
    busy_cnt_ff <= PROGRAM_CYCLES) else $error("busy too long");
endmodule : slave_checker
bind dual_address_i2c_memory_slave slave_checker #(.PROGRAM_CYCLES(PROGRAM_CYCLES)) chk (
  .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .eeprom_busy(eeprom_busy));
`default_nettype wire

// >>> test/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  // =====
  // clocks, open-drain wire, design and bus master
  logic       clk = 1'b0;
  logic       link_clk = 1'b0;
  logic       reset_n = 1'b0;
  logic       scl, m_low, sda_oe, sda_out, eeprom_busy, ak;
  wire logic  sda = !(m_low || (sda_oe && !sda_out));
  int         n_errors = 0;
  int         n_checks = 0;
  int         seed = 32;
  int         ctr = 0;
  logic [7:0] aux [256];
  logic [7:0] row, q, d;
  always #50 clk = !clk;
  initial begin
    #7;
    forever #15 link_clk = !link_clk;
  end
  dual_address_i2c_memory_slave #(.PROGRAM_CYCLES(400)) DUT (
    .clk(clk), .reset_n(reset_n), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .eeprom_busy(eeprom_busy));
  i2c_master_model m (.scl(scl), .sda_low(m_low), .sda(sda));
  // =====
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic send(input logic [7:0] b, input logic ok);
    m.xfer(b, 1'b1, q, ak);
    check({7'h00, ak}, {7'h00, !ok});
  endtask : send
  task automatic rd(input int n);
    for (int i = 0; i < n; i++) begin
      m.xfer(8'hFF, i == n - 1, q, ak);
      check(q, aux[ctr]);
      ctr = (ctr + 1) % 256;
    end
  endtask : rd
  task automatic settle;
    repeat (10) @(posedge clk);
    for (int i = 0; i < 3000 && eeprom_busy !== 1'b0; i++) @(posedge clk);
    check({7'h00, eeprom_busy}, 8'h00);
  endtask : settle
  task automatic conclude;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude
  initial begin
    #4000000;
    n_errors++;
    conclude;
  end
  // =====
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    #1 reset_n = 1'b1;
    repeat (3) @(posedge clk);
    check({7'h00, sda_oe}, 8'h00);
    check({7'h00, eeprom_busy}, 8'h00);
    // nine bytes from offset 6: the ninth lands on offset 6 again
    row = 8'($random(seed)) & 8'hF8;
    m.start;
    send(8'hA0, 1'b1);
    send(row | 8'h06, 1'b1);
    ctr = row | 8'h06;
    for (int i = 0; i < 9; i++) begin
      d = 8'($random(seed));
      send(d, 1'b1);
      aux[ctr] = d;
      ctr = {ctr[7:3], 3'(ctr[2:0] + 3'h1)};
    end
    m.stop;
    m.start;
    send(8'hA0, 1'b0);
    m.stop;
    check({7'h00, eeprom_busy}, 8'h01);
    for (int i = 0; i < 3000 && eeprom_busy !== 1'b0; i++) @(posedge clk);
    check({7'h00, eeprom_busy}, 8'h00);
    // dummy write then repeated start reads the whole row back
    m.start;
    send(8'hA0, 1'b1);
    send(row, 1'b1);
    ctr = row;
    m.start;
    send(8'hA1, 1'b1);
    rd(8);
    m.stop;
    m.start;
    send(8'hA0, 1'b1);
    send(row | 8'h05, 1'b1);
    ctr = row | 8'h05;
    m.stop;
    m.start;
    send(8'hA1, 1'b1);
    rd(3);
    m.stop;
    // main address moved onto A0h takes the auxiliary address over
    m.start;
    send(8'hA2, 1'b1);
    send(i2c_mem_pkg::REG_MAIN_SLAVE_ADDR, 1'b1);
    send(8'hA0, 1'b1);
    m.stop;
    settle;
    m.start;
    send(8'hA0, 1'b1);
    send(i2c_mem_pkg::REG_MAIN_SLAVE_ADDR, 1'b1);
    m.start;
    send(8'hA1, 1'b1);
    m.xfer(8'hFF, 1'b1, q, ak);
    check(q, 8'hA0);
    m.stop;
    // shadow bypass: a main write then leaves the programming timer idle
    m.start;
    send(8'hA0, 1'b1);
    send(i2c_mem_pkg::REG_SHADOW_CTRL, 1'b1);
    send(8'h01, 1'b1);
    m.stop;
    repeat (10) @(posedge clk);
    check({7'h00, eeprom_busy}, 8'h00);
    m.start;
    send(8'hA0, 1'b1);
    send(i2c_mem_pkg::REG_ADDR_SELECT, 1'b1);
    send(8'h00, 1'b1);
    m.stop;
    repeat (10) @(posedge clk);
    check({7'h00, eeprom_busy}, 8'h00);
    // foreign address: even an own address byte is ignored until a start
    m.start;
    send({1'b0, 7'($random(seed))}, 1'b0);
    send(8'hA0, 1'b0);
    m.start;
    send(8'hA2, 1'b0);
    m.stop;
    conclude;
  end
endmodule : testbench
`default_nettype wire
